// File: design/pwm_mode_pkg.sv
// constants and types for the class-d pwm mode control block
package pwm_mode_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SWITCHING = 8'h02;
  localparam logic [7:0] ADDR_POWER = 8'h03;
  localparam logic [7:0] ADDR_CH_SHIFT = 8'h53;
  localparam logic [7:0] ADDR_AGAIN = 8'h54;
  localparam logic [7:0] ADDR_PHASE_SEL = 8'h6A;
  localparam logic [7:0] ADDR_SS_ENABLE = 8'h6B;
  localparam logic [7:0] ADDR_SS_PROFILE = 8'h6C;
  localparam logic [7:0] ADDR_CLOCK_ERR = 8'h71;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_MOD = 2'h0;
  localparam logic [1:0] RST_POWER = 2'h0;
  localparam logic RST_CH_SHIFT = 1'b0;
  localparam logic [4:0] RST_AGAIN = 5'h00;
  localparam logic [3:0] RST_PHASE_SEL = 4'h0;
  localparam logic [1:0] RST_SS_ENABLE = 2'h0;
  localparam logic [2:0] RST_SS_PROFILE = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SS_EN_BIT = 0;
  localparam int SS_TRI_BIT = 1;
  localparam int PROF_FAST_BIT = 2;
  localparam logic [1:0] PHASE_SYNC_ON = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int SWITCH_FREQ_KHZ = 384;
  localparam int TRI_SLOW_KHZ = 24;
  localparam int TRI_FAST_KHZ = 48;
  localparam int BASE_PERIOD = CLK_FREQ_KHZ / SWITCH_FREQ_KHZ;
  localparam int TRI_SLOW_PERIODS = SWITCH_FREQ_KHZ / TRI_SLOW_KHZ;
  localparam int TRI_FAST_PERIODS = SWITCH_FREQ_KHZ / TRI_FAST_KHZ;
  localparam int PHASE_STEP = BASE_PERIOD / 8;
  localparam int IDLE_PCT = 17;
  localparam int SS_PCT0 = 5;
  localparam int SS_PCT1 = 10;
  localparam int SS_PCT2 = 20;
  localparam int SS_PCT3 = 25;
  localparam logic [8:0] GAIN_UNITY = 9'h100;
  localparam logic [9:0] FOLD_TICK_BASE = 10'h3FF;

  typedef enum logic [1:0] {PS_DEEP_SLEEP, PS_SLEEP, PS_HIZ, PS_PLAY} power_state_t;
  typedef enum logic [1:0] {MOD_BD, MOD_SINGLE_SIDE, MOD_HYBRID, MOD_SPARE} modulation_t;

endpackage : pwm_mode_pkg

// File: design/class_d_pwm_mode_control.sv
// pwm mode, power state, spread spectrum, phase and foldback control for a class-d stage
// Summary of operation
// - state 00: deep sleep, analog regulator off, core and register port on.
// - state 01: sleep, regulators on, no audio output.
// - state 10: only output drivers released to high impedance.
// - state 11: play, pwm pairs driven.
// - writing 11 alone resumes play from sleep or high impedance.
// - power-down pin low disables regulators and restores register defaults.
// - digital boost and volume stay at 0 dB whatever the analog gain.
// - five-bit analog gain code, 0.5 dB steps, 00000 full scale to 11111.
// - two-bit modulation select picks BD, single-side or hybrid.
// - BD: pair in phase at idle, duties split around half with signal.
// - single-side: idle near 17 percent, falling output rails, rising one modulates.
// - hybrid: duty follows signal level and configured supply value.
// - spread spectrum enabled with triangle in one register, profile in another.
// - profile codes 0-3 slow triangle, 4-7 fast; range 5,10,20,25 percent.
// - bit 0 of channel shift register gives 180 degree offset between channels.
// - phase select codes 03,07,0B,0F give 45 degree steps between devices.
// - host stops clock, sets phase, enters high impedance; device syncs on restart.
// - over-temperature warning ramps digital gain down, then back up when cleared.
// - parallel bridged: both pairs driven from the left sample.
// - bridged stereo: left drives pair A, right drives pair B.
// - stereo samples become two complementary pwm pairs.
// - halted audio clock forces high impedance and flags error; recovers by itself.
`timescale 1ns/1ps
module class_d_pwm_mode_control #(
  parameter int SAMPLE_W = 16
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [7:0] REG_RDATA,
  input wire logic SAMPLE_VALID,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_LEFT,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_RIGHT,
  input wire logic PARALLEL_MODE,
  input wire logic CLOCK_OK,
  input wire logic OVER_TEMP_WARN,
  input wire logic [7:0] FOLDBACK_LIMIT,
  input wire logic [1:0] FOLDBACK_ATTACK,
  input wire logic [1:0] FOLDBACK_RELEASE,
  input wire logic [7:0] SUPPLY_LEVEL,
  output logic [1:0] PAIR_POSITIVE_OUTPUT,
  output logic [1:0] PAIR_NEGATIVE_OUTPUT,
  output logic OUT_EN,
  output logic CLOCK_ERROR,
  output logic CORE_REG_EN,
  output logic ANALOG_REG_EN,
  output logic [4:0] ANALOG_GAIN,
  output logic [8:0] DIGITAL_GAIN,
  output logic [7:0] PWM_PERIOD
);
  import pwm_mode_pkg::*;

  initial begin
    if (SAMPLE_W < 8 || SAMPLE_W > 24) begin
      $error("SAMPLE_W must lie between 8 and 24");
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [1:0] mod_r;
  logic [1:0] power_r;
  logic ch_shift_r;
  logic [4:0] again_r;
  logic [3:0] phase_sel_r;
  logic [1:0] ss_en_r;
  logic [2:0] ss_prof_r;
  logic [7:0] rdata_r;
  logic clk_ok_r;
  logic core_on_r;

  wire wr_mod = REG_WE && REG_ADDR == ADDR_SWITCHING;
  wire wr_power = REG_WE && REG_ADDR == ADDR_POWER;
  wire wr_shift = REG_WE && REG_ADDR == ADDR_CH_SHIFT;
  wire wr_again = REG_WE && REG_ADDR == ADDR_AGAIN;
  wire wr_phase = REG_WE && REG_ADDR == ADDR_PHASE_SEL;
  wire wr_ss_en = REG_WE && REG_ADDR == ADDR_SS_ENABLE;
  wire wr_ss_prof = REG_WE && REG_ADDR == ADDR_SS_PROFILE;

  // reserved bits read as zero, unmapped offsets read as zero
  wire [7:0] rd_mux =
    (REG_ADDR == ADDR_SWITCHING) ? {6'h00, mod_r} :
    (REG_ADDR == ADDR_POWER) ? {6'h00, power_r} :
    (REG_ADDR == ADDR_CH_SHIFT) ? {7'h00, ch_shift_r} :
    (REG_ADDR == ADDR_AGAIN) ? {3'h0, again_r} :
    (REG_ADDR == ADDR_PHASE_SEL) ? {4'h0, phase_sel_r} :
    (REG_ADDR == ADDR_SS_ENABLE) ? {6'h00, ss_en_r} :
    (REG_ADDR == ADDR_SS_PROFILE) ? {5'h00, ss_prof_r} :
    (REG_ADDR == ADDR_CLOCK_ERR) ? {7'h00, ~clk_ok_r} : 8'h00;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      mod_r <= RST_MOD;
      power_r <= RST_POWER;
      ch_shift_r <= RST_CH_SHIFT;
      again_r <= RST_AGAIN;
      phase_sel_r <= RST_PHASE_SEL;
      ss_en_r <= RST_SS_ENABLE;
      ss_prof_r <= RST_SS_PROFILE;
      rdata_r <= 8'h00;
    end else begin
      if (wr_mod) mod_r <= REG_WDATA[1:0];
      // only the state field is needed to resume
      if (wr_power) power_r <= REG_WDATA[1:0];
      if (wr_shift) ch_shift_r <= REG_WDATA[0];
      if (wr_again) again_r <= REG_WDATA[4:0];
      if (wr_phase) phase_sel_r <= REG_WDATA[3:0];
      if (wr_ss_en) ss_en_r <= REG_WDATA[1:0];
      if (wr_ss_prof) ss_prof_r <= REG_WDATA[2:0];
      if (REG_RE) rdata_r <= rd_mux;
    end
  end

  assign REG_RDATA = rdata_r;
  // code passed straight to the analog gain stage
  assign ANALOG_GAIN = again_r;

  // ----------------------------------------------------------------
  // regulators and clock supervision
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      core_on_r <= 1'b0;
      clk_ok_r <= 1'b0;
    end else begin
      core_on_r <= 1'b1;
      clk_ok_r <= CLOCK_OK;
    end
  end

  // first cycle with a running clock after a halt or after reset
  wire clk_recover = CLOCK_OK && !clk_ok_r;

  // analog regulator off only in deep sleep
  assign CORE_REG_EN = core_on_r;
  assign ANALOG_REG_EN = core_on_r && power_r != PS_DEEP_SLEEP;
  // clock error flag follows the clock monitor
  assign CLOCK_ERROR = core_on_r && !clk_ok_r;

  // ----------------------------------------------------------------
  // pwm period and spread spectrum
  // ----------------------------------------------------------------
  function automatic logic [7:0] spread_dev(input logic [1:0] code);
    int pct;
    pct = (code == 2'h0) ? SS_PCT0 : (code == 2'h1) ? SS_PCT1 :
          (code == 2'h2) ? SS_PCT2 : SS_PCT3;
    return 8'((BASE_PERIOD * pct) / 200);
  endfunction : spread_dev

  logic [7:0] cnt_r;
  logic [7:0] period_r;
  logic [3:0] tri_ph_r;
  power_state_t eff_state_r;
  modulation_t eff_mod_r;
  logic eff_shift_r;

  wire wrap = cnt_r >= period_r - 8'h01;
  // both enable and triangle bits are needed
  wire ss_on = ss_en_r[SS_EN_BIT] && ss_en_r[SS_TRI_BIT];
  // fast triangle for codes 4 to 7
  wire prof_fast = ss_prof_r[PROF_FAST_BIT];
  wire [3:0] tri_last = prof_fast ? 4'(TRI_FAST_PERIODS - 1) : 4'(TRI_SLOW_PERIODS - 1);
  wire [3:0] tri_half = prof_fast ? 4'(TRI_FAST_PERIODS / 2) : 4'(TRI_SLOW_PERIODS / 2);
  // a profile change can leave the phase past the new end; ramp from zero then
  wire [3:0] ramp = (tri_ph_r > tri_last) ? 4'h0 :
    (tri_ph_r < tri_half) ? tri_ph_r : 4'(tri_last + 4'h1 - tri_ph_r);
  wire [7:0] dev = spread_dev(ss_prof_r[1:0]);
  wire [15:0] tri_prod = 16'({dev, 1'b0} * ramp);
  wire [7:0] tri_ofs = prof_fast ? 8'(tri_prod >> 2) : 8'(tri_prod >> 3);
  wire [7:0] period_nxt = ss_on ? 8'(8'(BASE_PERIOD) - dev + tri_ofs) : 8'(BASE_PERIOD);
  // 45 degree step per phase index when sync is on
  wire sync_on = phase_sel_r[1:0] == PHASE_SYNC_ON;
  wire [7:0] phase_ofs = sync_on ? 8'(phase_sel_r[3:2] * PHASE_STEP) : 8'h00;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_r <= 8'h00;
      period_r <= 8'(BASE_PERIOD);
      tri_ph_r <= 4'h0;
    end else if (clk_recover) begin
      // restart aligned to the selected phase
      cnt_r <= phase_ofs;
      tri_ph_r <= 4'h0;
    end else if (wrap) begin
      cnt_r <= 8'h00;
      period_r <= period_nxt;
      tri_ph_r <= (tri_ph_r >= tri_last) ? 4'h0 : tri_ph_r + 4'h1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign PWM_PERIOD = period_r;

  // settings take effect at a period boundary
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      eff_state_r <= PS_DEEP_SLEEP;
      eff_mod_r <= MOD_BD;
      eff_shift_r <= 1'b0;
    end else if (wrap) begin
      eff_state_r <= power_state_t'(power_r);
      eff_mod_r <= modulation_t'(mod_r);
      eff_shift_r <= ch_shift_r;
    end
  end

  // drivers enabled only in play with a clock
  assign OUT_EN = eff_state_r == PS_PLAY && clk_ok_r;

  // ----------------------------------------------------------------
  // thermal foldback gain
  // ----------------------------------------------------------------
  logic [8:0] gain_r;
  logic [11:0] fold_cnt_r;
  // one gain step per tick; the attack or release code stretches the tick
  wire [1:0] fold_sel = OVER_TEMP_WARN ? FOLDBACK_ATTACK : FOLDBACK_RELEASE;
  wire fold_tick = fold_cnt_r >= {fold_sel, FOLD_TICK_BASE};
  wire [8:0] gain_floor = {1'b0, FOLDBACK_LIMIT};

  // ramp down on warning, back to unity afterwards
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      gain_r <= GAIN_UNITY;
      fold_cnt_r <= 12'h000;
    end else begin
      fold_cnt_r <= fold_tick ? 12'h000 : fold_cnt_r + 12'h001;
      if (fold_tick && OVER_TEMP_WARN && gain_r > gain_floor) gain_r <= gain_r - 9'h001;
      else if (fold_tick && !OVER_TEMP_WARN && gain_r < GAIN_UNITY) gain_r <= gain_r + 9'h001;
    end
  end

  // unity is 0 dB; no boost applied for any analog code
  assign DIGITAL_GAIN = gain_r;

  // ----------------------------------------------------------------
  // per-channel duty and pwm compare
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0] smp_r [2];
  wire [7:0] half = period_r >> 1;
  wire [7:0] idle_ss = 8'((period_r * IDLE_PCT) / 100);

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [7:0] duty_p_r;
    logic [7:0] duty_n_r;
    logic [7:0] duty_p;
    logic [7:0] duty_n;
    logic signed [SAMPLE_W+9:0] scaled;
    logic signed [8:0] d;
    logic [7:0] mag;
    logic [7:0] idle;
    logic [7:0] ch_cnt;
    logic [8:0] cnt_sum;

    // pair B takes left in parallel mode, right otherwise
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) smp_r[ch] <= '0;
      else if (SAMPLE_VALID) smp_r[ch] <= (ch == 0 || PARALLEL_MODE) ? SAMPLE_LEFT : SAMPLE_RIGHT;
    end

    assign scaled = (SAMPLE_W+10)'((smp_r[ch] * $signed({1'b0, gain_r})) >>> 8);
    assign d = 9'((scaled * $signed({1'b0, half})) >>> (SAMPLE_W - 1));
    assign mag = d[8] ? 8'(-d) : 8'(d);
    // hybrid idle shrinks with supply and grows with signal level
    assign idle = (eff_mod_r == MOD_HYBRID) ?
      8'((16'(idle_ss) * (9'h100 - {1'b0, SUPPLY_LEVEL})) >> 8) + (mag >> 1) : idle_ss;

    always_comb begin
      duty_p = half;
      duty_n = half;
      unique case (eff_mod_r)
        // in phase at idle, split around half
        MOD_BD, MOD_SPARE: begin
          duty_p = 8'(half + 8'(d));
          duty_n = 8'(half - 8'(d));
        end
        // falling side rails, rising side carries signal
        MOD_SINGLE_SIDE, MOD_HYBRID: begin
          if (!d[8]) begin
            duty_p = (idle + mag > period_r) ? period_r : idle + mag;
            duty_n = (idle > mag) ? idle - mag : 8'h00;
          end else begin
            duty_n = (idle + mag > period_r) ? period_r : idle + mag;
            duty_p = (idle > mag) ? idle - mag : 8'h00;
          end
        end
      endcase
    end

    // pair B counts half a period later when the shift is on
    assign cnt_sum = {1'b0, cnt_r} + ((ch == 1 && eff_shift_r) ? {1'b0, half} : 9'h000);
    assign ch_cnt = (cnt_sum >= {1'b0, period_r}) ? 8'(cnt_sum - {1'b0, period_r}) : 8'(cnt_sum);

    // duties latched per period, outputs compared each cycle
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
        duty_p_r <= 8'h00;
        duty_n_r <= 8'h00;
        PAIR_POSITIVE_OUTPUT[ch] <= 1'b0;
        PAIR_NEGATIVE_OUTPUT[ch] <= 1'b0;
      end else begin
        if (wrap) begin
          duty_p_r <= duty_p;
          duty_n_r <= duty_n;
        end
        PAIR_POSITIVE_OUTPUT[ch] <= OUT_EN && ch_cnt < duty_p_r;
        PAIR_NEGATIVE_OUTPUT[ch] <= OUT_EN && ch_cnt < duty_n_r;
      end
    end

    bd_idle_phase_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      eff_mod_r == MOD_BD && d == 9'sh000 |-> duty_p == duty_n)
      else $error("bd idle duties differ");
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  deep_sleep_regs_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $past(ARST_N) && power_r == PS_DEEP_SLEEP |-> !ANALOG_REG_EN && CORE_REG_EN)
    else $error("deep sleep regulators wrong");

  non_play_hiz_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    eff_state_r != PS_PLAY |=> PAIR_POSITIVE_OUTPUT == 2'b00 && PAIR_NEGATIVE_OUTPUT == 2'b00)
    else $error("outputs switching outside play");

  play_resume_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wrap && power_r == PS_PLAY && CLOCK_OK |=> OUT_EN)
    else $error("play not resumed at boundary");

  clock_halt_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !CLOCK_OK |=> CLOCK_ERROR && !OUT_EN)
    else $error("halted clock not flagged");

  boundary_only_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !$stable(eff_mod_r) || !$stable(eff_state_r) |-> $past(wrap))
    else $error("setting changed mid period");

  spread_bounds_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wrap && ss_on |=> period_r >= 8'(BASE_PERIOD) - $past(dev) &&
      period_r <= 8'(BASE_PERIOD) + $past(dev))
    else $error("spread period out of range");

  phase_restart_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    clk_recover |=> cnt_r == $past(phase_ofs))
    else $error("phase offset not loaded");

  foldback_down_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    fold_tick && OVER_TEMP_WARN && gain_r > gain_floor |=> gain_r == $past(gain_r) - 9'h001)
    else $error("foldback did not attenuate");

  gain_ceiling_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    gain_r <= GAIN_UNITY)
    else $error("digital gain above 0 dB");

  parallel_left_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    SAMPLE_VALID && PARALLEL_MODE |=> smp_r[1] == smp_r[0])
    else $error("parallel pair not from left");

  reg_state_write_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_power |=> power_r == $past(REG_WDATA[1:0]))
    else $error("state write lost");

endmodule : class_d_pwm_mode_control

// File: tb/speaker_load_model.sv
// speaker load model: tallies driven output levels of both pwm pairs
`timescale 1ns/1ps
module speaker_load_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic out_en,
  input wire logic [1:0] pos,
  input wire logic [1:0] neg,
  output logic [15:0] cnt_pa,
  output logic [15:0] cnt_na,
  output logic [15:0] cnt_pb,
  output logic [15:0] cnt_nb,
  output logic [15:0] cnt_skew
);
  // ----------------------------------------------------------------
  // load current tally
  // ----------------------------------------------------------------
  // released drivers put no current into the load, so they add nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {cnt_pa, cnt_na, cnt_pb, cnt_nb, cnt_skew} <= '0;
    end else if (clear) begin
      {cnt_pa, cnt_na, cnt_pb, cnt_nb, cnt_skew} <= '0;
    end else if (out_en) begin
      cnt_pa <= cnt_pa + 16'(pos[0]);
      cnt_na <= cnt_na + 16'(neg[0]);
      cnt_pb <= cnt_pb + 16'(pos[1]);
      cnt_nb <= cnt_nb + 16'(neg[1]);
      cnt_skew <= cnt_skew + 16'(pos[0] ^ pos[1]);
    end
  end
endmodule : speaker_load_model

// File: tb/test_class_d_pwm_mode_control.sv
// self-checking bench for the class-d pwm mode control block
`timescale 1ns/1ps
module test_class_d_pwm_mode_control;
  import pwm_mode_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic sample_valid = 1'b0;
  logic signed [15:0] sample_left = 16'sh0000;
  logic signed [15:0] sample_right = 16'sh0000;
  logic parallel_mode = 1'b0;
  logic clock_ok = 1'b1;
  logic over_temp_warn = 1'b0;
  logic [7:0] foldback_limit = 8'h80;
  logic [1:0] foldback_attack = 2'h0;
  logic [1:0] foldback_release = 2'h0;
  logic [7:0] supply_level = 8'h00;
  logic clear = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] pos;
  logic [1:0] neg;
  logic out_en;
  logic clock_error;
  logic core_reg_en;
  logic analog_reg_en;
  logic [4:0] analog_gain;
  logic [8:0] digital_gain;
  logic [7:0] pwm_period;
  logic [15:0] cnt_pa;
  logic [15:0] cnt_na;
  logic [15:0] cnt_pb;
  logic [15:0] cnt_nb;
  logic [15:0] cnt_skew;
  logic [7:0] addrs [7] = '{ADDR_SWITCHING, ADDR_POWER, ADDR_CH_SHIFT, ADDR_AGAIN,
    ADDR_PHASE_SEL, ADDR_SS_ENABLE, ADDR_SS_PROFILE};
  integer seed = 32'h21fe;
  int fails = 0;
  int checked = 0;

  always #25 clk_sys = ~clk_sys;

  class_d_pwm_mode_control #(.SAMPLE_W(16)) i_class_d_pwm_mode_control (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .SAMPLE_VALID(sample_valid),
    .SAMPLE_LEFT(sample_left), .SAMPLE_RIGHT(sample_right), .PARALLEL_MODE(parallel_mode),
    .CLOCK_OK(clock_ok), .OVER_TEMP_WARN(over_temp_warn), .FOLDBACK_LIMIT(foldback_limit),
    .FOLDBACK_ATTACK(foldback_attack), .FOLDBACK_RELEASE(foldback_release),
    .SUPPLY_LEVEL(supply_level), .PAIR_POSITIVE_OUTPUT(pos), .PAIR_NEGATIVE_OUTPUT(neg),
    .OUT_EN(out_en), .CLOCK_ERROR(clock_error), .CORE_REG_EN(core_reg_en),
    .ANALOG_REG_EN(analog_reg_en), .ANALOG_GAIN(analog_gain), .DIGITAL_GAIN(digital_gain),
    .PWM_PERIOD(pwm_period));

  speaker_load_model i_speaker_load_model (
    .clk(clk_sys), .arst_n(arst_n), .clear(clear), .out_en(out_en), .pos(pos), .neg(neg),
    .cnt_pa(cnt_pa), .cnt_na(cnt_na), .cnt_pb(cnt_pb), .cnt_nb(cnt_nb), .cnt_skew(cnt_skew));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    case (a)
      ADDR_SWITCHING, ADDR_POWER, ADDR_SS_ENABLE: return 8'h03;
      ADDR_CH_SHIFT: return 8'h01;
      ADDR_AGAIN: return 8'h1F;
      ADDR_PHASE_SEL: return 8'h0F;
      ADDR_SS_PROFILE: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction : reg_mask

  function automatic int spread_dev(input int code);
    int pct;
    case (code % 4)
      0: pct = SS_PCT0;
      1: pct = SS_PCT1;
      2: pct = SS_PCT2;
      default: pct = SS_PCT3;
    endcase
    return BASE_PERIOD * pct / 200;
  endfunction : spread_dev

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ok(input string what, input logic c);
    chk(what, 16'h1, 16'(c));
  endtask : ok

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic send(input logic signed [15:0] l, input logic signed [15:0] r);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample_left <= l;
    sample_right <= r;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
  endtask : send

  // waits past two period boundaries so new settings reach the outputs
  task automatic settle;
    repeat (2 * BASE_PERIOD + 4) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic measure;
    @(posedge clk_sys);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    repeat (10 * BASE_PERIOD) @(posedge clk_sys);
    #1;
  endtask : measure

  task automatic check_defaults;
    logic [7:0] d;
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      chk("reset value", 16'h0, 16'(d));
    end
    chk("gain at reset", 16'(GAIN_UNITY), 16'(digital_gain));
    chk("period at reset", 16'(BASE_PERIOD), 16'(pwm_period));
    chk("analog reg deep sleep", 16'h0, 16'(analog_reg_en));
    ok("core reg on", core_reg_en);
  endtask : check_defaults

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #3000000;
    fails++;
    $display("BAD watchdog expected finish seen timeout");
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [15:0] h0;
    logic [15:0] lo;
    logic [15:0] hi;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    check_defaults();
    foreach (addrs[i]) begin
      v = 8'($random(seed));
      wr(addrs[i], v);
      rd(addrs[i], d);
      chk("readback", 16'(v & reg_mask(addrs[i])), 16'(d));
    end
    wr(8'h40, 8'hA5);
    rd(8'h40, d);
    chk("unmapped read", 16'h0, 16'(d));
    wr(ADDR_CLOCK_ERR, 8'hFF);
    rd(ADDR_CLOCK_ERR, d);
    chk("clock error read only", 16'h0, 16'(d));
    foreach (addrs[i]) wr(addrs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h1F : 8'($random(seed) & 8'h1F);
      wr(ADDR_AGAIN, v);
      settle();
      chk("analog gain", 16'(v), 16'(analog_gain));
      chk("digital boost", 16'(GAIN_UNITY), 16'(digital_gain));
    end
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_POWER, 8'(s));
      settle();
      chk("drivers on", 16'(s == 3), 16'(out_en));
      chk("analog reg", 16'(s != 0), 16'(analog_reg_en));
    end
    wr(ADDR_POWER, 8'h01);
    settle();
    wr(ADDR_POWER, 8'h03);
    settle();
    ok("sleep to play", out_en);
    send(16'sh0000, 16'sh0000);
    settle();
    measure();
    chk("bd idle in phase", cnt_pa, cnt_na);
    ok("bd idle switching", cnt_pa != 0);
    send({3'b001, 13'($random(seed))}, -{3'b001, 13'($random(seed))});
    settle();
    measure();
    ok("left positive", cnt_pa > cnt_na);
    ok("right negative", cnt_pb < cnt_nb);
    @(posedge clk_sys);
    parallel_mode <= 1'b1;
    send(sample_left, sample_right);
    settle();
    measure();
    ok("parallel from left", cnt_pb > cnt_nb);
    chk("no channel shift", 16'h0, cnt_skew);
    wr(ADDR_CH_SHIFT, 8'h01);
    settle();
    measure();
    ok("channel shift", cnt_skew != 0);
    wr(ADDR_CH_SHIFT, 8'h00);
    @(posedge clk_sys);
    parallel_mode <= 1'b0;
    wr(ADDR_SWITCHING, 8'(MOD_SINGLE_SIDE));
    send(16'sh0000, 16'sh0000);
    settle();
    measure();
    lo = 16'(10 * (BASE_PERIOD * IDLE_PCT / 100 - 1));
    hi = 16'(10 * (BASE_PERIOD * IDLE_PCT / 100 + 1));
    ok("single side idle", cnt_pa >= lo && cnt_pa <= hi);
    send(16'sh3000, 16'sh3000);
    settle();
    measure();
    chk("falling output rails", 16'h0, cnt_na);
    ok("rising output modulates", cnt_pa > hi);
    wr(ADDR_SWITCHING, 8'(MOD_HYBRID));
    send(16'sh0000, 16'sh0000);
    settle();
    measure();
    h0 = cnt_pa;
    @(posedge clk_sys);
    supply_level <= 8'hC0;
    settle();
    measure();
    ok("hybrid follows supply", cnt_pa < h0);
    wr(ADDR_SWITCHING, 8'h00);
    wr(ADDR_SS_ENABLE, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_SS_PROFILE, 8'(c));
      settle();
      lo = 16'hFFFF;
      hi = 16'h0000;
      repeat (1000) begin
        @(posedge clk_sys);
        #1;
        if (pwm_period < lo) lo = 16'(pwm_period);
        if (pwm_period > hi) hi = 16'(pwm_period);
      end
      chk("spread low", 16'(BASE_PERIOD - spread_dev(c)), lo);
      chk("spread high", 16'(BASE_PERIOD + spread_dev(c)), hi);
    end
    wr(ADDR_SS_ENABLE, 8'h00);
    @(posedge clk_sys);
    clock_ok <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    ok("clock error flag", clock_error);
    chk("halt releases", 16'h0, 16'(out_en));
    rd(ADDR_CLOCK_ERR, d);
    chk("clock error reg", 16'h1, 16'(d));
    @(posedge clk_sys);
    clock_ok <= 1'b1;
    settle();
    ok("play resumes", out_en);
    // host phase alignment: clock stopped, phase chosen, drivers released
    @(posedge clk_sys);
    clock_ok <= 1'b0;
    wr(ADDR_PHASE_SEL, 8'h0B);
    wr(ADDR_POWER, 8'h02);
    @(posedge clk_sys);
    clock_ok <= 1'b1;
    settle();
    chk("clock recovered", 16'h0, 16'(clock_error));
    rd(ADDR_PHASE_SEL, d);
    chk("phase select", 16'h0B, 16'(d));
    wr(ADDR_POWER, 8'h03);
    @(posedge clk_sys);
    foldback_attack <= 2'($random(seed) & 1);
    foldback_release <= 2'($random(seed) & 1);
    over_temp_warn <= 1'b1;
    repeat (3000) @(posedge clk_sys);
    #1;
    h0 = 16'(digital_gain);
    ok("gain reduced", h0 < 16'(GAIN_UNITY) && h0 >= 16'(foldback_limit));
    @(posedge clk_sys);
    over_temp_warn <= 1'b0;
    repeat (3000) @(posedge clk_sys);
    #1;
    ok("gain restored", 16'(digital_gain) > h0);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    check_defaults();
    finish_test();
  end
endmodule : test_class_d_pwm_mode_control
